/* File: rtl/pbc_defines.svh */
/*
 * Object indices, subindices, preset values and bit-rate codes for the
 * program and bus configuration objects.
 * Assumes: included by its bare name from files that need these constants.
 */
`ifndef PBC_DEFINES_SVH
`define PBC_DEFINES_SVH

// object indices
`define PBC_IDX_PROG_DATA    16'h1f50
`define PBC_IDX_PROG_CTRL    16'h1f51
`define PBC_IDX_PROG_STAT    16'h1f57
`define PBC_IDX_STARTUP      16'h1f80
`define PBC_IDX_BIT_RATE     16'h2005

// subindices
`define PBC_SUB_COUNT        8'h00
`define PBC_SUB_AREA_BOOT    8'h01
`define PBC_SUB_AREA_SCRIPT  8'h02

// preset values
`define PBC_AREA_COUNT       8'h02
`define PBC_CTRL_RST         8'h00
`define PBC_STAT_RST         32'h0000_0000
`define PBC_STARTUP_RST      32'h0000_0000
`define PBC_STARTUP_OPER_BIT 3
`define PBC_RATE_RST         8'h88

// bit-rate codes and their rates in kBd
`define PBC_RATE_10          8'h81
`define PBC_RATE_20          8'h82
`define PBC_RATE_50          8'h83
`define PBC_RATE_125         8'h84
`define PBC_RATE_250         8'h85
`define PBC_RATE_500         8'h86
`define PBC_RATE_1000        8'h88
`define PBC_KBD_10           11'h00a
`define PBC_KBD_20           11'h014
`define PBC_KBD_50           11'h032
`define PBC_KBD_125          11'h07d
`define PBC_KBD_250          11'h0fa
`define PBC_KBD_500          11'h1f4
`define PBC_KBD_1000         11'h3e8

`endif

/* File: rtl/pbc_pkg.sv */
/*
 * Types shared by the program and bus configuration objects.
 * Assumes: compiled before any module that imports it.
 */
package pbc_pkg;

    // network management state, one-hot
    typedef enum logic [2:0] {
        PBC_NMT_INIT  = 3'b001,
        PBC_NMT_PREOP = 3'b010,
        PBC_NMT_OPER  = 3'b100
    } pbc_nmt_t;

    typedef logic [10:0] pbc_kbd_t;

endpackage : pbc_pkg

/* File: rtl/pbc_rate_decode.sv */
/*
 * Bit-rate code decoder: turns the active 8-bit code into a rate in kBd.
 * Assumes: code comes from a register on the same clock, changed only at
 * initialization by the parent.
 */
`timescale 1ns/1ps
`include "pbc_defines.svh"

module pbc_rate_decode
    import pbc_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic [7:0] code,
    output pbc_kbd_t        kbd_r
);

    pbc_kbd_t kbd_nxt;

    // anything else runs at full rate
    always_comb begin
        case (code)
            `PBC_RATE_10:   kbd_nxt = `PBC_KBD_10;
            `PBC_RATE_20:   kbd_nxt = `PBC_KBD_20;
            `PBC_RATE_50:   kbd_nxt = `PBC_KBD_50;
            `PBC_RATE_125:  kbd_nxt = `PBC_KBD_125;
            `PBC_RATE_250:  kbd_nxt = `PBC_KBD_250;
            `PBC_RATE_500:  kbd_nxt = `PBC_KBD_500;
            `PBC_RATE_1000: kbd_nxt = `PBC_KBD_1000;
            default:        kbd_nxt = `PBC_KBD_1000;
        endcase
    end

    // registered so the rate output never glitches
    always_ff @(posedge mclk) begin
        if (rst) begin
            kbd_r <= `PBC_KBD_1000;
        end else begin
            kbd_r <= kbd_nxt;
        end
    end

endmodule : pbc_rate_decode

/* File: rtl/pbc_objects.sv */
/*
 * Program and bus configuration object entries: program data, control and
 * status per memory area, startup state selection and bus bit-rate setting,
 * reached by index and subindex over an object access port.
 * Assumes: requests, programming engine and reset request are on mclk.
 */
// Functional notes
// - program data has count 2 and writable entries for firmware and script areas
// - program control has count 2 and an 8-bit entry per area, zero after start
// - per-area 32-bit read-only status, zero until programming changes it
// - startup setting zero (preset) leads to pre-operational after initialization
// - startup bit 3 set leads to operational after initialization
// - rate codes 81..86,88 give 10,20,50,125,250,500,1000 kBd; preset 88
// - any unlisted rate code runs the bus at 1000 kBd
`timescale 1ns/1ps
`include "pbc_defines.svh"

module pbc_objects
    import pbc_pkg::*;
#(
    parameter int AREA_CNT = 2
)(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [15:0] obj_index,
    input  wire logic [7:0]  obj_sub,
    input  wire logic        obj_rd,
    input  wire logic        obj_wr,
    input  wire logic [31:0] obj_wdata,
    output logic             obj_ack,
    output logic             obj_err,
    output logic [31:0]      obj_rdata,
    output logic [31:0]      prog_word,
    output logic             prog_area,
    output logic             prog_valid,
    output logic [7:0]       prog_ctrl_boot,
    output logic [7:0]       prog_ctrl_script,
    input  wire logic        stat_load,
    input  wire logic        stat_area,
    input  wire logic [31:0] stat_value,
    input  wire logic        comm_reinit,
    output pbc_nmt_t         nmt_state,
    output logic [7:0]       bus_rate_code,
    output pbc_kbd_t         bus_rate_kbd
);

    // the map holds exactly two areas; the subindex decode depends on it
    if (AREA_CNT != 2) begin : g_area_check
        $error("pbc_objects: AREA_CNT must be 2");
    end

    // true when the request addresses one of the two per-area subindices
    function automatic logic is_area(input logic [7:0] sub);
        is_area = (sub == `PBC_SUB_AREA_BOOT) || (sub == `PBC_SUB_AREA_SCRIPT);
    endfunction : is_area

    // area number of a per-area subindex: 0 firmware, 1 script
    function automatic logic area_of(input logic [7:0] sub);
        area_of = (sub == `PBC_SUB_AREA_SCRIPT);
    endfunction : area_of

    logic [7:0]  ctrl_r [2];
    logic [7:0]  ctrl_nxt [2];
    logic [31:0] stat_r [2];
    logic [31:0] stat_nxt [2];
    logic [31:0] startup_r, startup_nxt;
    logic [7:0]  rate_sel_r, rate_sel_nxt;
    logic [7:0]  rate_act_r, rate_act_nxt;
    pbc_nmt_t    nmt_r, nmt_nxt;
    logic        ack_r, ack_nxt;
    logic        err_r, err_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [31:0] pword_r, pword_nxt;
    logic        parea_r, parea_nxt;
    logic        pvalid_r, pvalid_nxt;

    // object access: decode, register updates and the one-cycle answer
    always_comb begin
        logic req;
        logic hit;
        logic ro;
        req          = obj_rd | obj_wr;
        hit          = 1'b0;
        ro           = 1'b0;
        ctrl_nxt     = ctrl_r;
        stat_nxt     = stat_r;
        startup_nxt  = startup_r;
        rate_sel_nxt = rate_sel_r;
        rdata_nxt    = rdata_r;
        pword_nxt    = pword_r;
        parea_nxt    = parea_r;
        pvalid_nxt   = 1'b0;
        case (obj_index)
            `PBC_IDX_PROG_DATA, `PBC_IDX_PROG_CTRL, `PBC_IDX_PROG_STAT: begin
                hit = (obj_sub == `PBC_SUB_COUNT) || is_area(obj_sub);
                ro  = (obj_sub == `PBC_SUB_COUNT) || (obj_index == `PBC_IDX_PROG_STAT);
            end
            `PBC_IDX_STARTUP, `PBC_IDX_BIT_RATE: begin
                hit = (obj_sub == `PBC_SUB_COUNT);
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        // both strobes at once, unknown entries and writes to read-only fail
        err_nxt = req & ((obj_rd & obj_wr) | !hit | (obj_wr & ro));
        ack_nxt = req;
        if (obj_rd && !err_nxt) begin
            rdata_nxt = 32'h0000_0000;
            case (obj_index)
                `PBC_IDX_PROG_DATA, `PBC_IDX_PROG_CTRL, `PBC_IDX_PROG_STAT: begin
                    if (obj_sub == `PBC_SUB_COUNT) begin
                        rdata_nxt = {24'h00_0000, `PBC_AREA_COUNT};
                    end else if (obj_index == `PBC_IDX_PROG_CTRL) begin
                        rdata_nxt = {24'h00_0000, ctrl_r[area_of(obj_sub)]};
                    end else if (obj_index == `PBC_IDX_PROG_STAT) begin
                        rdata_nxt = stat_r[area_of(obj_sub)];
                    end
                    // a domain entry is write-only data; it reads back as zero
                end
                `PBC_IDX_STARTUP: begin
                    rdata_nxt = startup_r;
                end
                default: begin
                    rdata_nxt = {24'h00_0000, rate_sel_r};
                end
            endcase
        end
        if (obj_wr && !err_nxt) begin
            case (obj_index)
                `PBC_IDX_PROG_DATA: begin
                    pword_nxt  = obj_wdata;
                    parea_nxt  = area_of(obj_sub);
                    pvalid_nxt = 1'b1;
                end
                `PBC_IDX_PROG_CTRL: begin
                    ctrl_nxt[area_of(obj_sub)] = obj_wdata[7:0];
                end
                `PBC_IDX_STARTUP: begin
                    startup_nxt = obj_wdata;
                end
                default: begin
                    rate_sel_nxt = obj_wdata[7:0];
                end
            endcase
        end
        // status changes only by programming activity
        if (stat_load) begin
            stat_nxt[stat_area] = stat_value;
        end
    end

    // registers of the access port and the entries
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_r     <= '{`PBC_CTRL_RST, `PBC_CTRL_RST};
            stat_r     <= '{`PBC_STAT_RST, `PBC_STAT_RST};
            startup_r  <= `PBC_STARTUP_RST;
            rate_sel_r <= `PBC_RATE_RST;
            rdata_r    <= 32'h0000_0000;
            ack_r      <= 1'b0;
            err_r      <= 1'b0;
            pword_r    <= 32'h0000_0000;
            parea_r    <= 1'b0;
            pvalid_r   <= 1'b0;
        end else begin
            ctrl_r     <= ctrl_nxt;
            stat_r     <= stat_nxt;
            startup_r  <= startup_nxt;
            rate_sel_r <= rate_sel_nxt;
            rdata_r    <= rdata_nxt;
            ack_r      <= ack_nxt;
            err_r      <= err_nxt;
            pword_r    <= pword_nxt;
            parea_r    <= parea_nxt;
            pvalid_r   <= pvalid_nxt;
        end
    end

    // startup state machine; init lasts one cycle and loads the bus rate
    always_comb begin
        nmt_nxt      = nmt_r;
        rate_act_nxt = rate_act_r;
        case (nmt_r)
            PBC_NMT_INIT: begin
                rate_act_nxt = rate_sel_r;
                nmt_nxt = startup_r[`PBC_STARTUP_OPER_BIT] ? PBC_NMT_OPER : PBC_NMT_PREOP;
            end
            PBC_NMT_PREOP, PBC_NMT_OPER: begin
                nmt_nxt = nmt_r;
            end
            default: begin
                nmt_nxt = PBC_NMT_INIT;
            end
        endcase
        // a reset request restarts initialization from any state
        if (comm_reinit) begin
            nmt_nxt = PBC_NMT_INIT;
        end
    end

    // preset rate active from reset so the bus can talk before init ends
    always_ff @(posedge mclk) begin
        if (rst) begin
            nmt_r      <= PBC_NMT_INIT;
            rate_act_r <= `PBC_RATE_RST;
        end else begin
            nmt_r      <= nmt_nxt;
            rate_act_r <= rate_act_nxt;
        end
    end

    pbc_rate_decode u_rate (
        .mclk  (mclk),
        .rst   (rst),
        .code  (rate_act_r),
        .kbd_r (bus_rate_kbd)
    );

    assign obj_ack          = ack_r;
    assign obj_err          = err_r;
    assign obj_rdata        = rdata_r;
    assign prog_word        = pword_r;
    assign prog_area        = parea_r;
    assign prog_valid       = pvalid_r;
    assign prog_ctrl_boot   = ctrl_r[0];
    assign prog_ctrl_script = ctrl_r[1];
    assign nmt_state        = nmt_r;
    assign bus_rate_code    = rate_act_r;

    // checks on the entries and the startup behaviour
    a_count_reads_two: assert property (@(posedge mclk) disable iff (rst)
        obj_rd && !obj_wr && obj_sub == `PBC_SUB_COUNT && obj_index == `PBC_IDX_PROG_DATA
        |=> obj_ack && !obj_err && obj_rdata == 32'h0000_0002)
        else $error("program data entry count not two");
    a_domain_stream: assert property (@(posedge mclk) disable iff (rst)
        obj_wr && !obj_rd && obj_index == `PBC_IDX_PROG_DATA && obj_sub == `PBC_SUB_AREA_SCRIPT
        |=> prog_valid && prog_area && prog_word == $past(obj_wdata))
        else $error("script domain write not passed on");
    a_ctrl_write_holds: assert property (@(posedge mclk) disable iff (rst)
        obj_wr && !obj_rd && obj_index == `PBC_IDX_PROG_CTRL && obj_sub == `PBC_SUB_AREA_BOOT
        |=> prog_ctrl_boot == $past(obj_wdata[7:0]) && !obj_err)
        else $error("firmware control byte not stored");
    a_ctrl_reset_zero: assert property (@(posedge mclk) disable iff (rst)
        $fell(rst) |-> prog_ctrl_boot == 8'h00 && prog_ctrl_script == 8'h00)
        else $error("control bytes not zero after reset");
    a_stat_readonly: assert property (@(posedge mclk) disable iff (rst)
        obj_wr && obj_index == `PBC_IDX_PROG_STAT |=> obj_ack && obj_err)
        else $error("status write not refused");
    a_stat_reset_zero: assert property (@(posedge mclk) disable iff (rst)
        $fell(rst) |-> stat_r[0] == 32'h0000_0000 && stat_r[1] == 32'h0000_0000)
        else $error("status not zero after reset");
    a_startup_preop: assert property (@(posedge mclk) disable iff (rst)
        nmt_state == PBC_NMT_INIT && !startup_r[3] && !comm_reinit ##1 !comm_reinit
        |-> nmt_state == PBC_NMT_PREOP [*2])
        else $error("startup zero did not give pre-operational");
    a_startup_oper: assert property (@(posedge mclk) disable iff (rst)
        nmt_state == PBC_NMT_INIT && startup_r[3] && !comm_reinit
        |=> nmt_state == PBC_NMT_OPER)
        else $error("startup bit 3 did not give operational");
    a_rate_decode: assert property (@(posedge mclk) disable iff (rst)
        nmt_state == PBC_NMT_INIT && rate_sel_r == `PBC_RATE_125 && !comm_reinit
        |=> ##1 bus_rate_kbd == `PBC_KBD_125)
        else $error("code 84 not decoded as 125 kBd");
    a_rate_fallback: assert property (@(posedge mclk) disable iff (rst)
        nmt_state == PBC_NMT_INIT && rate_sel_r == 8'h87 && !comm_reinit
        |=> ##1 bus_rate_kbd == `PBC_KBD_1000)
        else $error("unlisted code not run at 1000 kBd");
    a_rate_held: assert property (@(posedge mclk) disable iff (rst)
        nmt_state != PBC_NMT_INIT |=> $stable(bus_rate_code))
        else $error("bus rate changed outside initialization");

    c_oper_start: cover property (@(posedge mclk) disable iff (rst)
        nmt_state == PBC_NMT_INIT ##1 nmt_state == PBC_NMT_OPER);
    c_rate_change: cover property (@(posedge mclk) disable iff (rst)
        $changed(bus_rate_code));
    c_status_load: cover property (@(posedge mclk) disable iff (rst)
        stat_load && stat_value != 32'h0000_0000);

endmodule : pbc_objects

/* File: verif/pbc_master_model.sv */
/*
 * Master model: issues object reads and writes, one at a time.
 * Assumes: the block answers each request on obj_ack within a few mclk cycles.
 */
`timescale 1ns/1ps

module pbc_master_model (
    input  wire logic        mclk,
    output logic [15:0]      obj_index,
    output logic [7:0]       obj_sub,
    output logic             obj_rd,
    output logic             obj_wr,
    output logic [31:0]      obj_wdata,
    input  wire logic        obj_ack,
    input  wire logic        obj_err,
    input  wire logic [31:0] obj_rdata
);
    // idle before the first request
    initial begin
        obj_index = 16'h0000;
        obj_sub = 8'h00;
        obj_rd = 1'b0;
        obj_wr = 1'b0;
        obj_wdata = 32'h0000_0000;
    end

    // one request: strobe one cycle, qualifiers held up to the ack edge
    task automatic access(input logic rd, input logic wr, input logic [15:0] idx,
                          input logic [7:0] sub, input logic [31:0] wd,
                          output logic err, output logic [31:0] rdat, output bit hung);
        hung = 1'b1;
        err = 1'b0;
        rdat = 32'h0000_0000;
        @(posedge mclk);
        #1;
        obj_rd = rd;
        obj_wr = wr;
        obj_index = idx;
        obj_sub = sub;
        obj_wdata = wd;
        @(posedge mclk);
        #1;
        obj_rd = 1'b0;
        obj_wr = 1'b0;
        for (int i = 0; i < 4 && hung; i++) begin
            @(posedge mclk);
            if (obj_ack === 1'b1) begin
                hung = 1'b0;
                err = obj_err;
                rdat = obj_rdata;
            end
        end
        #1;
        // released lines flip so a late sample never sees a valid-looking value
        obj_index = ~idx;
        obj_sub = ~sub;
        obj_wdata = ~wd;
    endtask : access
endmodule : pbc_master_model

/* File: verif/pbc_objects_test.sv */
/*
 * Self-checking bench: reference values kept in integers, compared at every answer.
 * Assumes: package, defines, design and master model compiled before it.
 */
`timescale 1ns/1ps
`include "pbc_defines.svh"

module pbc_objects_test
    import pbc_pkg::*;
;
    logic        mclk = 1'b0;
    logic        rst, stat_load, stat_area, comm_reinit;
    logic [31:0] stat_value, wd, sv, su, pv_word;
    logic [15:0] obj_index;
    logic [7:0]  obj_sub, prog_ctrl_boot, prog_ctrl_script, bus_rate_code, act_m;
    logic        obj_rd, obj_wr, obj_ack, obj_err, prog_area, prog_valid, pv_area;
    logic [31:0] obj_wdata, obj_rdata, prog_word;
    pbc_nmt_t    nmt_state;
    pbc_kbd_t    bus_rate_kbd;
    logic [7:0]  codes[10];
    int          ctrl_m[2];
    int          pv_cnt = 0;
    int          n, n_mismatch, checks_done;

    always #4 mclk = ~mclk;

    pbc_objects #(.AREA_CNT(2)) u_dut (.mclk(mclk), .rst(rst), .obj_index(obj_index),
        .obj_sub(obj_sub), .obj_rd(obj_rd), .obj_wr(obj_wr), .obj_wdata(obj_wdata),
        .obj_ack(obj_ack), .obj_err(obj_err), .obj_rdata(obj_rdata), .prog_word(prog_word),
        .prog_area(prog_area), .prog_valid(prog_valid), .prog_ctrl_boot(prog_ctrl_boot),
        .prog_ctrl_script(prog_ctrl_script), .stat_load(stat_load), .stat_area(stat_area),
        .stat_value(stat_value), .comm_reinit(comm_reinit), .nmt_state(nmt_state),
        .bus_rate_code(bus_rate_code), .bus_rate_kbd(bus_rate_kbd));

    pbc_master_model u_mst (.mclk(mclk), .obj_index(obj_index), .obj_sub(obj_sub),
        .obj_rd(obj_rd), .obj_wr(obj_wr), .obj_wdata(obj_wdata), .obj_ack(obj_ack),
        .obj_err(obj_err), .obj_rdata(obj_rdata));

    // count domain pulses; sampled at the edge so the pulse is never missed
    always @(posedge mclk) begin
        if (prog_valid === 1'b1) begin
            pv_cnt <= pv_cnt + 1;
            pv_word <= prog_word;
            pv_area <= prog_area;
        end
    end

    function automatic int ref_kbd(input logic [7:0] c);
        case (c)
            8'h81: return 10;
            8'h82: return 20;
            8'h83: return 50;
            8'h84: return 125;
            8'h85: return 250;
            8'h86: return 500;
            default: return 1000;
        endcase
    endfunction : ref_kbd

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one request through the master; a hung answer ends the run
    task automatic xfer(input logic rd, input logic wr, input logic [15:0] idx,
                        input logic [7:0] sub, input logic [31:0] d,
                        input logic exp_err, input logic [31:0] exp_rd);
        logic        err;
        logic [31:0] data;
        bit          hung;
        u_mst.access(rd, wr, idx, sub, d, err, data, hung);
        if (hung) begin
            n_mismatch++;
            end_sim();
        end
        chk({31'h0, err}, {31'h0, exp_err});
        if (rd && !wr && !exp_err) begin
            chk(data, exp_rd);
        end
    endtask : xfer

    // one-cycle pulse of either the reinit request or a status load
    task automatic side_pulse(input bit reinit, input logic area, input logic [31:0] v);
        @(posedge mclk);
        #1;
        comm_reinit = reinit;
        stat_load = !reinit;
        stat_area = area;
        stat_value = v;
        @(posedge mclk);
        #1;
        comm_reinit = 1'b0;
        stat_load = 1'b0;
        stat_value = ~v;
        if (reinit) begin
            repeat (2) @(posedge mclk);
            #1;
        end
    endtask : side_pulse

    task automatic do_reset;
        rst = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        rst = 1'b0;
    endtask : do_reset

    task automatic check_presets;
        xfer(1, 0, `PBC_IDX_PROG_DATA, 8'h00, 0, 0, 32'h2);
        xfer(1, 0, `PBC_IDX_PROG_CTRL, 8'h00, 0, 0, 32'h2);
        xfer(1, 0, `PBC_IDX_PROG_STAT, 8'h00, 0, 0, 32'h2);
        for (int a = 1; a <= 2; a++) begin
            xfer(1, 0, `PBC_IDX_PROG_CTRL, 8'(a), 0, 0, 32'h0);
            xfer(1, 0, `PBC_IDX_PROG_STAT, 8'(a), 0, 0, 32'h0);
        end
        xfer(1, 0, `PBC_IDX_STARTUP, 8'h00, 0, 0, 32'h0);
        xfer(1, 0, `PBC_IDX_BIT_RATE, 8'h00, 0, 0, 32'h88);
        chk({29'h0, nmt_state}, {29'h0, PBC_NMT_PREOP});
        chk({24'h0, bus_rate_code}, 32'h88);
        chk({21'h0, bus_rate_kbd}, 32'd1000);
    endtask : check_presets

    initial begin
        {stat_load, stat_area, comm_reinit, stat_value} = '0;
        n_mismatch = 0;
        checks_done = 0;
        act_m = 8'h88;
        void'($urandom(6));
        do_reset();
        check_presets();
        $display("test presets done");
        for (int a = 1; a <= 2; a++) begin
            wd = $urandom;
            n = pv_cnt;
            xfer(0, 1, `PBC_IDX_PROG_DATA, 8'(a), wd, 0, 0);
            chk(32'(pv_cnt), 32'(n + 1));
            chk({31'h0, pv_area}, 32'(a - 1));
            chk(pv_word, wd);
            ctrl_m[a - 1] = $urandom_range(255);
            xfer(0, 1, `PBC_IDX_PROG_CTRL, 8'(a), 32'(ctrl_m[a - 1]), 0, 0);
            xfer(1, 0, `PBC_IDX_PROG_CTRL, 8'(a), 0, 0, 32'(ctrl_m[a - 1]));
            sv = $urandom;
            side_pulse(0, 1'(a - 1), sv);
            xfer(0, 1, `PBC_IDX_PROG_STAT, 8'(a), ~sv, 1, 0);
            xfer(1, 0, `PBC_IDX_PROG_STAT, 8'(a), 0, 0, sv);
        end
        chk({24'h0, prog_ctrl_boot}, 32'(ctrl_m[0]));
        chk({24'h0, prog_ctrl_script}, 32'(ctrl_m[1]));
        // refused requests must leave every entry alone
        n = pv_cnt;
        xfer(0, 1, `PBC_IDX_PROG_CTRL, 8'h00, 32'h5, 1, 0);
        xfer(1, 0, `PBC_IDX_PROG_CTRL, 8'h00, 0, 0, 32'h2);
        xfer(0, 1, `PBC_IDX_PROG_DATA, 8'h00, 32'h7, 1, 0);
        xfer(1, 1, `PBC_IDX_PROG_DATA, 8'h01, 32'h7, 1, 0);
        chk(32'(pv_cnt), 32'(n));
        xfer(1, 0, 16'h1f52, 8'h00, 0, 1, 0);
        xfer(0, 1, `PBC_IDX_STARTUP, 8'h01, 32'h8, 1, 0);
        $display("test program areas done");
        for (int k = 0; k < 2; k++) begin
            su = (k == 0) ? 32'h8 : 32'h0;
            xfer(0, 1, `PBC_IDX_STARTUP, 8'h00, su, 0, 0);
            xfer(1, 0, `PBC_IDX_STARTUP, 8'h00, 0, 0, su);
            side_pulse(1, 0, 0);
            chk({29'h0, nmt_state}, {29'h0, (k == 0) ? PBC_NMT_OPER : PBC_NMT_PREOP});
        end
        $display("test startup done");
        codes = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h88, 8'h87, 8'h00, 8'h00};
        codes[9] = 8'($urandom);
        for (int k = 0; k < 10; k++) begin
            xfer(0, 1, `PBC_IDX_BIT_RATE, 8'h00, {24'h0, codes[k]}, 0, 0);
            xfer(1, 0, `PBC_IDX_BIT_RATE, 8'h00, 0, 0, {24'h0, codes[k]});
            chk({24'h0, bus_rate_code}, {24'h0, act_m});
            side_pulse(1, 0, 0);
            act_m = codes[k];
            chk({24'h0, bus_rate_code}, {24'h0, act_m});
            chk({21'h0, bus_rate_kbd}, 32'(ref_kbd(act_m)));
        end
        $display("test bit rates done");
        do_reset();
        act_m = 8'h88;
        check_presets();
        $display("test second reset done");
        end_sim();
    end
endmodule : pbc_objects_test
